// ==== rtl/ubr_backoff.sv ====
// Terminal-side bandwidth request and contention back-off logic.
// Assumes frame logic on i_sys_clk gives one-cycle event pulses.
//
// Function
// [RQ1] Poll allocations target single terminals only
// [RQ2] Polled with empty queue: send empty request
// [RQ3] Each header carries aggregate queue-depth byte
// [RQ4] Depth 0..254 direct, 255+ saturates ones
// [RQ5] Poll flag marks traffic in other aggregates
// [RQ6] Contention burst carries only short requests
// [RQ7] Contention procedure is optional, enable bit
// [RQ8] Opportunities counted from scheduled window size
// [RQ9] Access point sets and broadcasts window limits
// [RQ10] Window exponent n spans 0..2^n-1
// [RQ11] Entering contention loads initial window
// [RQ12] Random count chooses opportunities to skip
// [RQ13] No response in interval means lost
// [RQ14] Loss doubles window while below maximum
// [RQ15] Loss redraws random count, repeats deferral
// [RQ16] Stop retries at broadcast maximum count
// [RQ17] Contention window marked by usage code
// [RQ18] Grant during deferral abandons contention
// [RQ19] Retries exhausted: wait grant, use header
// [RQ20] Depth byte eight bits beside 16-bit id
// [RQ21] Poll flag one asks, zero declines
// [RQ22] LFSR draw, decrement per opportunity
// [RQ23] Answer or grant resets retries, window
`timescale 1ns/1ps
`default_nettype none

module ubr_backoff (
  // Clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_resetn,
  // Avalon-MM slave
  input  wire logic [ubr_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [ubr_pkg::DATA_W-1:0] i_avs_writedata,
  output logic      [ubr_pkg::DATA_W-1:0] o_avs_readdata,
  output logic                         o_avs_waitrequest,
  // Frame events and header input
  input  wire ubr_pkg::ubr_evt_type    i_evt,
  input  wire logic [ubr_pkg::CID_W-1:0] i_hdr_cid,
  // Header and request outputs
  output ubr_pkg::ubr_hdr_type         o_hdr,
  output logic                         o_hdr_valid,
  output logic                         o_req_contention,
  output logic                         o_req_granted,
  output logic                         o_req_empty
);
  import ubr_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Saturating queue-depth encoding
  function automatic logic [QDB_W-1:0] enc_depth(input logic [QCNT_W-1:0] cnt);
    if (cnt >= QCNT_W'(QDB_SAT))
      enc_depth = QDB_SAT;                                   // [RQ4]
    else
      enc_depth = cnt[QDB_W-1:0];                            // [RQ4]
  endfunction

  // Window mask 2^n-1 for exponent n
  function automatic logic [LFSR_W-1:0] win_mask(input logic [EXP_W-1:0] e);
    win_mask = LFSR_W'((32'h1 << e) - 32'h1);                // [RQ10]
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Register file state
  logic                 en_q, en_d;
  logic                 other_q, other_d;
  logic [QCNT_W-1:0]    qcnt_q, qcnt_d;
  logic [EXP_W-1:0]     init_exp_q, init_exp_d;
  logic [EXP_W-1:0]     max_exp_q, max_exp_d;
  logic [RETRY_W-1:0]   max_retry_q, max_retry_d;
  logic                 start_d;
  logic [DATA_W-1:0]    rdata_q, rdata_d;
  logic                 ack_q, ack_d;
  logic                 wait_q, wait_d;

  // Contention state
  ubr_state_type        st_q, st_d;
  logic [EXP_W-1:0]     win_q, win_d;
  logic [RETRY_W-1:0]   retry_q, retry_d;
  logic [LFSR_W-1:0]    defer_q, defer_d;
  logic [LFSR_W-1:0]    lfsr_q, lfsr_d;
  logic                 pend_q, pend_d;
  logic                 exh_q, exh_d;

  // Outputs
  ubr_hdr_type          hdr_q, hdr_d;
  logic                 hdr_v_q, hdr_v_d;
  logic                 rc_q, rc_d, rg_q, rg_d, re_q, re_d;

  ////////////////////////////////////////////////////////////////////
  // Bus decode: one wait cycle, then answer
  always_comb begin
    en_d        = en_q;
    other_d     = other_q;
    qcnt_d      = qcnt_q;
    init_exp_d  = init_exp_q;
    max_exp_d   = max_exp_q;
    max_retry_d = max_retry_q;
    start_d     = 1'b0;
    rdata_d     = rdata_q;
    ack_d       = 1'b0;
    wait_d      = 1'b1;
    // Writes land only on the edge where the master sees waitrequest low
    if (i_avs_write && ack_q) begin
      case (i_avs_address)
        REG_CTRL: begin
          en_d    = i_avs_writedata[CTRL_EN_BIT];            // [RQ7]
          start_d = i_avs_writedata[CTRL_START_BIT];
          other_d = i_avs_writedata[CTRL_OTHER_BIT];
          qcnt_d  = i_avs_writedata[CTRL_QCNT_LSB +: QCNT_W];
        end
        REG_BCAST: begin
          init_exp_d  = i_avs_writedata[BC_INIT_LSB +: EXP_W];
          max_exp_d   = i_avs_writedata[BC_MAX_LSB +: EXP_W];
          max_retry_d = i_avs_writedata[BC_RETRY_LSB +: RETRY_W];
        end
        default: ;
      endcase
    end
    // Read data built at the taking edge so it stands at the answer edge
    if ((i_avs_read || i_avs_write) && !ack_q) begin
      ack_d   = 1'b1;
      wait_d  = 1'b0;
      rdata_d = '0;
      if (i_avs_read) begin
        case (i_avs_address)
          REG_CTRL: begin
            rdata_d[CTRL_EN_BIT]                 = en_q;
            rdata_d[CTRL_OTHER_BIT]              = other_q;
            rdata_d[CTRL_QCNT_LSB +: QCNT_W]     = qcnt_q;
          end
          REG_BCAST: begin
            rdata_d[BC_INIT_LSB +: EXP_W]        = init_exp_q;
            rdata_d[BC_MAX_LSB +: EXP_W]         = max_exp_q;
            rdata_d[BC_RETRY_LSB +: RETRY_W]     = max_retry_q;
          end
          REG_STATUS: begin
            rdata_d[STAT_ST_LSB +: $bits(ubr_state_type)] = st_q;
            rdata_d[STAT_PEND_BIT]                       = pend_q;
            rdata_d[STAT_EXH_BIT]                        = exh_q;
            rdata_d[STAT_WIN_LSB +: EXP_W]               = win_q;
            rdata_d[STAT_RETRY_LSB +: RETRY_W]           = retry_q;
          end
          REG_HDR: begin
            rdata_d[HDR_QDB_LSB +: QDB_W] = hdr_q.queue_depth_byte;
            rdata_d[HDR_POLL_BIT]         = hdr_q.request_poll_flag;
            rdata_d[HDR_CID_LSB +: CID_W] = hdr_q.cid;
          end
          default: ;   // Unmapped reads as zero
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_q        <= 1'b0;
      other_q     <= 1'b0;
      qcnt_q      <= '0;
      init_exp_q  <= INIT_EXP_RST;
      max_exp_q   <= MAX_EXP_RST;
      max_retry_q <= MAX_RETRY_RST;
      rdata_q     <= '0;
      ack_q       <= 1'b0;
      wait_q      <= 1'b1;
    end else begin
      en_q        <= en_d;
      other_q     <= other_d;
      qcnt_q      <= qcnt_d;
      init_exp_q  <= init_exp_d;
      max_exp_q   <= max_exp_d;
      max_retry_q <= max_retry_d;
      rdata_q     <= rdata_d;
      ack_q       <= ack_d;
      wait_q      <= wait_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Contention back-off machine; grants always take priority
  always_comb begin
    st_d    = st_q;
    win_d   = win_q;
    retry_d = retry_q;
    defer_d = defer_q;
    pend_d  = pend_q || start_d;
    exh_d   = exh_q;
    rc_d    = 1'b0;
    rg_d    = 1'b0;
    re_d    = 1'b0;
    // Galois LFSR steps every cycle
    lfsr_d  = {1'b0, lfsr_q[LFSR_W-1:1]} ^ (lfsr_q[0] ? LFSR_TAPS : '0);   // [RQ22]
    hdr_d   = hdr_q;
    hdr_v_d = 1'b0;
    // Header fields for each data unit
    if (i_evt.hdr_req) begin
      hdr_d.cid               = i_hdr_cid;                                 // [RQ20]
      hdr_d.queue_depth_byte  = enc_depth(qcnt_q);                         // [RQ3]
      hdr_d.request_poll_flag = other_q ? POLL_WANTED : POLL_NOT_WANTED;   // [RQ5] [RQ21]
      hdr_v_d                 = 1'b1;
    end
    if (i_evt.grant) begin
      // Granted/polled burst: request there, empty if no traffic
      rg_d    = 1'b1;                                                      // [RQ18]
      re_d    = (qcnt_q == '0) && !other_q;                                // [RQ2]
      st_d    = ST_IDLE;
      win_d   = init_exp_q;                                                // [RQ23]
      retry_d = '0;
      pend_d  = start_d;  // A start in this same cycle still counts
      exh_d   = 1'b0;                                                      // [RQ19]
    end else begin
      case (st_q)
        ST_IDLE: begin
          // Exhausted terminals wait for a grant instead
          if (pend_q && en_q && !exh_q) begin                              // [RQ7] [RQ19]
            win_d   = init_exp_q;                                          // [RQ11]
            defer_d = lfsr_q & win_mask(init_exp_q);                       // [RQ12]
            retry_d = '0;
            st_d    = ST_DEFER;
          end
        end
        ST_DEFER: begin
          // Frame logic pulses once per opportunity in the window
          if (i_evt.opp) begin                                             // [RQ8] [RQ17]
            if (defer_q == '0) begin
              rc_d = 1'b1;                                                 // [RQ6]
              st_d = ST_WAIT;
            end else begin
              defer_d = defer_q - LFSR_W'(1);                              // [RQ22]
            end
          end
        end
        ST_WAIT: begin
          if (i_evt.answer) begin
            st_d    = ST_IDLE;
            pend_d  = start_d;
            win_d   = init_exp_q;                                          // [RQ23]
            retry_d = '0;
          end else if (i_evt.timeout) begin                                // [RQ13]
            if (retry_q + RETRY_W'(1) >= max_retry_q) begin                // [RQ16]
              st_d  = ST_GRANTW;
              exh_d = 1'b1;
            end else begin
              retry_d = retry_q + RETRY_W'(1);
              if (win_q < max_exp_q) begin
                win_d   = win_q + EXP_W'(1);                               // [RQ14]
                defer_d = lfsr_q & win_mask(win_q + EXP_W'(1));            // [RQ15]
              end else begin
                defer_d = lfsr_q & win_mask(win_q);                        // [RQ15]
              end
              st_d = ST_DEFER;
            end
          end
        end
        ST_GRANTW: st_d = ST_GRANTW;                                       // [RQ19]
        default:   st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q    <= ST_IDLE;
      win_q   <= INIT_EXP_RST;
      retry_q <= '0;
      defer_q <= '0;
      lfsr_q  <= LFSR_SEED;
      pend_q  <= 1'b0;
      exh_q   <= 1'b0;
      hdr_q   <= '0;
      hdr_v_q <= 1'b0;
      rc_q    <= 1'b0;
      rg_q    <= 1'b0;
      re_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      win_q   <= win_d;
      retry_q <= retry_d;
      defer_q <= defer_d;
      lfsr_q  <= lfsr_d;
      pend_q  <= pend_d;
      exh_q   <= exh_d;
      hdr_q   <= hdr_d;
      hdr_v_q <= hdr_v_d;
      rc_q    <= rc_d;
      rg_q    <= rg_d;
      re_q    <= re_d;
    end
  end

  // Outputs straight from flops
  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_hdr             = hdr_q;
  assign o_hdr_valid       = hdr_v_q;
  assign o_req_contention  = rc_q;
  assign o_req_granted     = rg_q;
  assign o_req_empty       = re_q;

endmodule

`default_nettype wire

// ==== rtl/ubr_pkg.sv ====
// Package for the uplink bandwidth-request back-off block.
// Assumes a single 100 MHz clock domain and an Avalon-MM register master.
package ubr_pkg;

  // Bus and register map
  localparam int unsigned ADDR_W            = 4;
  localparam int unsigned DATA_W            = 32;
  localparam logic [3:0]  REG_CTRL          = 4'h0;  // Enable, start, queue inputs
  localparam logic [3:0]  REG_BCAST         = 4'h4;  // Broadcast back-off parameters
  localparam logic [3:0]  REG_STATUS        = 4'h8;  // State, window, retries
  localparam logic [3:0]  REG_HDR           = 4'hC;  // Last header fields built

  // Field layout of REG_CTRL
  localparam int unsigned CTRL_EN_BIT       = 0;
  localparam int unsigned CTRL_START_BIT    = 1;
  localparam int unsigned CTRL_OTHER_BIT    = 2;
  localparam int unsigned CTRL_QCNT_LSB     = 16;
  localparam int unsigned QCNT_W            = 16;

  // Field layout of REG_BCAST
  localparam int unsigned BC_INIT_LSB       = 0;
  localparam int unsigned BC_MAX_LSB        = 8;
  localparam int unsigned BC_RETRY_LSB      = 16;
  localparam int unsigned EXP_W             = 4;
  localparam int unsigned RETRY_W           = 8;

  // Field layout of REG_STATUS and REG_HDR
  localparam int unsigned STAT_ST_LSB       = 0;
  localparam int unsigned STAT_PEND_BIT     = 3;
  localparam int unsigned STAT_EXH_BIT      = 4;
  localparam int unsigned STAT_WIN_LSB      = 8;
  localparam int unsigned STAT_RETRY_LSB    = 16;
  localparam int unsigned HDR_QDB_LSB       = 0;
  localparam int unsigned HDR_POLL_BIT      = 8;
  localparam int unsigned HDR_CID_LSB       = 16;

  // Reset values of broadcast parameters
  localparam logic [3:0]  INIT_EXP_RST      = 4'h4;
  localparam logic [3:0]  MAX_EXP_RST       = 4'hA;
  localparam logic [7:0]  MAX_RETRY_RST     = 8'h10;

  // Header encoding
  localparam int unsigned QDB_W             = 8;
  localparam int unsigned CID_W             = 16;
  localparam logic [7:0]  QDB_SAT           = 8'hFF;
  localparam logic        POLL_WANTED       = 1'b1;
  localparam logic        POLL_NOT_WANTED   = 1'b0;

  // Random generator
  localparam int unsigned LFSR_W            = 16;
  localparam logic [15:0] LFSR_SEED         = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS         = 16'hB400;

  // Contention state machine, Gray-ordered codes; ST_SEND is never entered, so DEFER to WAIT flips two bits
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEFER  = 3'b001,
    ST_SEND   = 3'b011,
    ST_WAIT   = 3'b010,
    ST_GRANTW = 3'b110
  } ubr_state_type;

  // Uplink data unit header request fields
  typedef struct packed {
    logic [CID_W-1:0] cid;
    logic [QDB_W-1:0] queue_depth_byte;
    logic             request_poll_flag;
  } ubr_hdr_type;

  // Frame events from the MAC frame logic
  typedef struct packed {
    logic opp;       // Contention opportunity passes
    logic grant;     // Individual grant or poll for this terminal
    logic answer;    // Response to our contention request
    logic timeout;   // Response interval expired
    logic hdr_req;   // Build a data unit header
  } ubr_evt_type;

endpackage

// ==== tb/ubr_backoff_props.sv ====
// Checker for the bandwidth-request block, bound to its top ports.
// Assumes one clock domain and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ubr_backoff_props (
  // Clock and reset
  input wire logic                        i_sys_clk,
  input wire logic                        i_resetn,
  // Observed ports
  input wire logic                        i_avs_read,
  input wire logic                        i_avs_write,
  input wire logic                        o_avs_waitrequest,
  input wire ubr_pkg::ubr_evt_type        i_evt,
  input wire logic [ubr_pkg::CID_W-1:0]   i_hdr_cid,
  input wire ubr_pkg::ubr_hdr_type        o_hdr,
  input wire logic                        o_hdr_valid,
  input wire logic                        o_req_contention,
  input wire logic                        o_req_granted,
  input wire logic                        o_req_empty
);
  import ubr_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  //////////////////////////////
  // Bus handshake steps
  sequence s_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_ack;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_taken |=> s_ack)
    else $error("bus request not answered in one cycle");
  // Header pulse carries the sampled connection id
  a_hdr_follows: assert property (i_evt.hdr_req |=> o_hdr_valid && o_hdr.cid == $past(i_hdr_cid))
    else $error("header not built after request");
  a_hdr_cause: assert property (o_hdr_valid |-> $past(i_evt.hdr_req))
    else $error("header without request");
  // Grant always wins, one cycle later
  a_grant_taken: assert property (i_evt.grant |=> o_req_granted)
    else $error("grant not used");
  a_granted_cause: assert property (o_req_granted |-> $past(i_evt.grant))
    else $error("granted request without grant");
  a_empty_granted: assert property (o_req_empty |-> o_req_granted)
    else $error("empty request outside a grant");
  // Contention sends only on an opportunity, never beside a grant
  a_cont_cause: assert property (o_req_contention |-> $past(i_evt.opp) && !$past(i_evt.grant))
    else $error("contention request without opportunity");
  a_cont_single: assert property (o_req_contention |=> !o_req_contention [*2])
    else $error("contention request repeated");
endmodule
bind ubr_backoff ubr_backoff_props chk_u (.i_sys_clk, .i_resetn, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_evt, .i_hdr_cid, .o_hdr, .o_hdr_valid, .o_req_contention,
  .o_req_granted, .o_req_empty);
`default_nettype wire

// ==== tb/ubr_ap_model.sv ====
// Access point scheduler model: forwards events, answers contention requests.
// Assumes the bench pulses i_cmd for one cycle on i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ubr_ap_model (
  // Clock and bench commands
  input  wire logic                 i_sys_clk,
  input  wire ubr_pkg::ubr_evt_type i_cmd,
  input  wire logic                 i_lose,
  input  wire logic                 i_slow,
  // Terminal side
  input  wire logic                 i_req_contention,
  output ubr_pkg::ubr_evt_type      o_evt
);
  import ubr_pkg::*;
  int cnt = 0;
  ubr_evt_type nxt;
  initial o_evt = '0;
  //////////////////////////////
  // Grants name this terminal alone; opportunities mark the window
  // Slow mode tests a late answer; lose mode lets the interval expire
  always @(posedge i_sys_clk) begin
    nxt = i_cmd;
    if (i_req_contention) cnt <= i_slow ? 9 : 2;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt <= 0;
      nxt.answer = !i_lose;
      nxt.timeout = i_lose;
    end
    o_evt <= nxt;
  end
endmodule
`default_nettype wire

// ==== tb/ubr_backoff_tb.sv ====
// Testbench for the bandwidth-request block: bus, event and compare tasks.
// Assumes the access point model answers contention requests itself.
`timescale 1ns/1ps
`default_nettype none
module ubr_backoff_tb;
  import ubr_pkg::*;
  localparam ubr_evt_type OPP = 5'h10, GNT = 5'h08, HREQ = 5'h01;
  logic              clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, lose = 1'b0, slow = 1'b0;
  logic              wreq, rc, rg, re, hvld;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0, rdat, q;
  logic [CID_W-1:0]  cid = '0;
  logic [7:0]        d;
  logic [15:0]       qc [6] = '{16'h0000, 16'h0001, 16'h00FE, 16'h00FF, 16'h0100, 16'hFFFF};
  logic [3:0]        wx [4] = '{4'h0, 4'h1, 4'h2, 4'h2};
  ubr_evt_type       cmd = '0, evt;
  ubr_hdr_type       hdr, last_hdr;
  int                n_fail = 0, total_checks = 0, n_cont = 0, n_grant = 0, n_empty = 0, k, c0;
  always #5 clk = ~clk;
  ubr_backoff dut_u (.i_sys_clk(clk), .i_resetn(resetn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_evt(evt), .i_hdr_cid(cid), .o_hdr(hdr), .o_hdr_valid(hvld), .o_req_contention(rc),
    .o_req_granted(rg), .o_req_empty(re));
  ubr_ap_model ap_u (.i_sys_clk(clk), .i_cmd(cmd), .i_lose(lose), .i_slow(slow),
    .i_req_contention(rc), .o_evt(evt));
  //////////////////////////////
  // Pulses are counted here so tests compare totals, not moments
  always @(posedge clk) begin
    if (rc === 1'b1) n_cont <= n_cont + 1;
    if (rg === 1'b1) n_grant <= n_grant + 1;
    if (re === 1'b1) n_empty <= n_empty + 1;
    if (hvld === 1'b1) last_hdr <= hdr;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Held until waitrequest is seen low, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= v;
    // Only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, REG_STATUS, '0);
    chk(q & m, e);
  endtask
  // Extra edges let the model, the design and the counters settle
  task automatic ev(input ubr_evt_type e);
    cmd <= e;
    @(posedge clk);
    cmd <= '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, REG_BCAST, '0);
    chk(q, {8'h00, MAX_RETRY_RST, 4'h0, MAX_EXP_RST, 4'h0, INIT_EXP_RST});
    bus(1'b0, 4'h2, '0);
    chk(q, '0);
    // Depth byte boundaries with the poll flag both ways
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, REG_CTRL, {qc[i], 13'h0000, i[0], 2'h0});
      cid <= 16'hA500 + 16'(i);
      ev(HREQ);
      d = (qc[i] > 16'h00FE) ? QDB_SAT : qc[i][7:0];
      chk({7'h00, last_hdr}, {7'h00, cid, d, i[0]});
    end
    bus(1'b0, REG_HDR, '0);
    chk(q, {16'hA505, 7'h00, 1'b1, QDB_SAT});
    bus(1'b1, REG_CTRL, '0);
    ev(GNT);
    chk(n_empty, 1);
    bus(1'b1, REG_CTRL, 32'h0005_0000);
    bus(1'b0, REG_CTRL, '0);
    chk(q, 32'h0005_0000);
    ev(GNT);
    chk(n_grant - n_empty, 1);
    bus(1'b1, REG_CTRL, 32'h0000_0002);
    st(32'hF, {28'h0, 1'b1, ST_IDLE});
    // Default window: transmit within sixteen opportunities, answered late
    slow <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h0000_0003);
    st(32'hF07, {20'h0, INIT_EXP_RST, 5'h00, ST_DEFER});
    c0 = n_cont;
    for (k = 0; k < 17 && n_cont == c0; k++) ev(OPP);
    chk(n_cont - c0, 1);
    chk(k <= 16, 1);
    repeat (12) @(posedge clk);
    st(32'hFF0007, 32'(ST_IDLE));
    bus(1'b1, REG_CTRL, 32'h0000_0003);
    st(32'h7, 32'(ST_DEFER));
    ev(GNT);
    st(32'h7, 32'(ST_IDLE));
    chk(n_grant, 3);
    // Every request lost until the retries run out
    lose <= 1'b1;
    slow <= 1'b0;
    bus(1'b1, REG_BCAST, 32'h0003_0200);
    bus(1'b1, REG_CTRL, 32'h0000_0003);
    for (int r = 0; r < 3; r++) begin
      c0 = n_cont;
      for (k = 0; k < 5 && n_cont == c0; k++) ev(OPP);
      chk(k <= (1 << wx[r]), 1);
      repeat (4) @(posedge clk);
      st(32'hF17, {20'h0, wx[r + 1], 3'h0, r == 2, 1'b0,
        (r == 2) ? ST_GRANTW : ST_DEFER});
      if (r < 2) chk(q[23:16], r + 1);
    end
    ev(OPP);
    chk(n_cont, c0 + 1);
    ev(GNT);
    st(32'hFF0F17, 32'h0);
    print_verdict;
  end
  // A few hundred cycles suffice; this cuts a hang short
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
endmodule
`default_nettype wire
